// ---- hdl/iad_pkg.sv ----
/*
 * Shared constants, types and decode functions for the indirect address
 * decoder: region bounds, data memory layout, flash geometry and the
 * packed request and memory strobe carriers.
 * Assumes one core clock and a synchronous active-high reset.
 */
package iad_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PTR_W    = 16;
    localparam int DATA_W   = 8;
    localparam int MEM_AW   = 12;
    localparam int FLASH_AW = 15;
    localparam int FLASH_DW = 14;  // Program word width, plain default
    localparam int BANK_W   = 5;
    localparam int OFS_W    = 7;

    // ------------------------------------------------------------
    // Region bounds of the pointer space
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0] TRAD_FIRST = 16'h0000;
    localparam logic [PTR_W-1:0] TRAD_LAST  = 16'h0FFF;
    localparam logic [PTR_W-1:0] LIN_FIRST  = 16'h2000;
    localparam logic [PTR_W-1:0] LIN_LAST   = 16'h29AF;
    localparam int               FLASH_BIT  = 15;

    // ------------------------------------------------------------
    // Bank layout of data memory
    // ------------------------------------------------------------
    localparam logic [OFS_W-1:0]  GPR_FIRST    = 7'h20;
    localparam logic [MEM_AW-1:0] GPR_BYTES    = 12'h050;
    localparam logic [OFS_W-1:0]  PORT0_OFS    = 7'h00;
    localparam logic [OFS_W-1:0]  PORT1_OFS    = 7'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
    localparam int                NUM_PAIRS    = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RGN_NONE,
        RGN_TRAD,
        RGN_LIN,
        RGN_FLASH
    } iad_region_e;

    // Access through an indirect data port
    typedef struct packed {
        logic              valid;
        logic              pair;
        logic              write;
        logic [DATA_W-1:0] wdata;
    } iad_req_s;

    // Byte load of one pointer half
    typedef struct packed {
        logic              valid;
        logic              pair;
        logic              high;
        logic [DATA_W-1:0] data;
    } iad_ptr_wr_s;

    // Strobes toward banked data memory
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } iad_mem_s;

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic iad_region_e region_of(input logic [PTR_W-1:0] p);
        iad_region_e r;
        r = RGN_NONE;
        if (p[FLASH_BIT]) begin
            r = RGN_FLASH;
        end else if (p <= TRAD_LAST) begin
            r = RGN_TRAD;
        end else if (p >= LIN_FIRST && p <= LIN_LAST) begin
            r = RGN_LIN;
        end
        return r;
    endfunction

    // Port registers are mirrored at the same offset in every bank
    function automatic logic is_port_addr(input logic [MEM_AW-1:0] a);
        return (a[OFS_W-1:0] == PORT0_OFS) || (a[OFS_W-1:0] == PORT1_OFS);
    endfunction

endpackage

// ---- hdl/iad_linear_map.sv ----
/*
 * Folds a linear-region pointer onto the absolute data memory address of
 * the banked general purpose byte that it aliases.
 * Assumes the pointer lies inside the linear region; outside it the
 * result is meaningless and the caller ignores it.
 */
`timescale 1ns/1ns

module iad_linear_map
    import iad_pkg::*;
(
    // Pointer in
    input  wire logic [iad_pkg::PTR_W-1:0]  ptr_i,
    // Absolute address out
    output logic      [iad_pkg::MEM_AW-1:0] addr_o
);

    logic [PTR_W-1:0]  diff;
    logic [MEM_AW-1:0] offset;
    logic [MEM_AW-1:0] quot;
    logic [MEM_AW-1:0] remd;
    logic [OFS_W-1:0]  in_bank;

    // Division by a constant; small enough to stay combinational
    assign diff    = ptr_i - LIN_FIRST;
    assign offset  = diff[MEM_AW-1:0];
    assign quot    = offset / GPR_BYTES;
    assign remd    = offset % GPR_BYTES;
    assign in_bank = GPR_FIRST + remd[OFS_W-1:0];
    // Carry into the next bank happens through the quotient
    assign addr_o  = {quot[BANK_W-1:0], in_bank};

endmodule

// ---- hdl/iad_decoder.sv ----
/*
 * Indirect address decoder: holds the two file select pointers and turns
 * each access through an indirect data port into a data memory or
 * program flash access, or into a zero read and a dropped write.
 * Assumes data memory answers in the cycle of its strobe, flash answers
 * by the second cycle of its strobe, and the core waits for done_o.
 */
// Functional notes
// - An access through a data port really reaches the location its pointer selects; the port stores nothing.
// - A pointer aimed at either data port reads zero and drops the write, while status may still change.
// - Each pointer is its high byte placed above its low byte, a 16-bit address over 65536 locations.
// - Pointers 0x000 to 0xFFF are the absolute addresses of all banked and common registers.
// - Pointers 0x2000 to 0x29AF alias the 80-byte general purpose block of banks 0 to 30 end to end.
// - Reads of unimplemented locations return 0x00.
// - In the linear region, stepping past one bank's last general byte lands on the next bank's first.
// - The 16 common bytes of each bank are not part of the linear region.
// - With the top pointer bit set, the low 15 bits address a program flash word.
// - A flash read returns only the low 8 bits of the word.
// - Writes aimed at flash leave flash untouched.
// - Any flash access through a port takes one extra cycle.
`timescale 1ns/1ns

module iad_decoder
    import iad_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    // Pointer byte loads from the core
    input  wire iad_pkg::iad_ptr_wr_s         ptr_wr_i,
    // Port access from the core
    input  wire iad_pkg::iad_req_s            req_i,
    output logic                              busy_o,
    output logic                              done_o,
    output logic      [iad_pkg::DATA_W-1:0]   rdata_o,
    // Pointer readback
    output logic      [iad_pkg::PTR_W-1:0]    ptr0_o,
    output logic      [iad_pkg::PTR_W-1:0]    ptr1_o,
    // Data memory
    output iad_pkg::iad_mem_s                 mem_o,
    input  wire logic [iad_pkg::DATA_W-1:0]   mem_rdata_i,
    input  wire logic                         mem_hit_i,
    // Program flash
    output logic                              flash_rd_o,
    output logic      [iad_pkg::FLASH_AW-1:0] flash_addr_o,
    input  wire logic [iad_pkg::FLASH_DW-1:0] flash_rdata_i
);

    import iad_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_FLASH1,
        ST_FLASH2
    } iad_state_e;

    iad_state_e        state;
    iad_state_e        next_state;
    logic [DATA_W-1:0] ptr_low  [NUM_PAIRS];
    logic [DATA_W-1:0] ptr_high [NUM_PAIRS];
    logic              zero_read;
    logic              write_acc;

    // ------------------------------------------------------------
    // Per-pair decode
    // ------------------------------------------------------------
    logic [PTR_W-1:0]  ptr_full  [NUM_PAIRS];
    logic [MEM_AW-1:0] lin_addr  [NUM_PAIRS];
    iad_region_e       pair_rgn  [NUM_PAIRS];

    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
            // High byte above low byte
            assign ptr_full[g] = {ptr_high[g], ptr_low[g]};
            // Same region rules for each pair
            assign pair_rgn[g] = region_of(ptr_full[g]);
            iad_linear_map u_lin (
                .ptr_i  (ptr_full[g]),
                .addr_o (lin_addr[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Selected pair
    // ------------------------------------------------------------
    logic [PTR_W-1:0]  sel_ptr;
    iad_region_e       sel_rgn;
    logic [MEM_AW-1:0] sel_mem_addr;
    logic              sel_port_hit;
    logic              take;
    logic              to_data;
    logic              to_flash;

    assign sel_ptr  = req_i.pair ? ptr_full[1] : ptr_full[0];
    assign sel_rgn  = req_i.pair ? pair_rgn[1] : pair_rgn[0];
    // Low twelve bits are already the absolute address
    assign sel_mem_addr = (sel_rgn == RGN_LIN) ?
                          (req_i.pair ? lin_addr[1] : lin_addr[0]) :
                          sel_ptr[MEM_AW-1:0];
    // Only the traditional region can reach a port register
    assign sel_port_hit = (sel_rgn == RGN_TRAD) && is_port_addr(sel_mem_addr);
    assign take     = req_i.valid && (state == ST_IDLE);
    assign to_data  = ((sel_rgn == RGN_TRAD) || (sel_rgn == RGN_LIN)) && !sel_port_hit;
    assign to_flash = (sel_rgn == RGN_FLASH);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = to_flash ? ST_FLASH1 : ST_DATA;
                end
            end
            ST_DATA:   next_state = ST_IDLE;
            ST_FLASH1: next_state = ST_FLASH2;
            ST_FLASH2: next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Pointer registers
    // ------------------------------------------------------------
    // A load in the taking cycle only affects later accesses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
                ptr_low[i]  <= 8'h00;
                ptr_high[i] <= 8'h00;
            end
        end else if (ptr_wr_i.valid) begin
            if (ptr_wr_i.high) begin
                ptr_high[ptr_wr_i.pair] <= ptr_wr_i.data;
            end else begin
                ptr_low[ptr_wr_i.pair]  <= ptr_wr_i.data;
            end
        end
    end

    // Readback mirrors the registers one cycle later
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptr0_o <= 16'h0000;
            ptr1_o <= 16'h0000;
        end else begin
            ptr0_o <= ptr_full[0];
            ptr1_o <= ptr_full[1];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state     <= ST_IDLE;
            busy_o    <= 1'b0;
            zero_read <= 1'b0;
            write_acc <= 1'b0;
        end else begin
            state     <= next_state;
            busy_o    <= (next_state != ST_IDLE);
            if (take) begin
                // Holes between regions behave like unimplemented memory
                zero_read <= !to_data && !to_flash;
                write_acc <= req_i.write;
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory strobes
    // ------------------------------------------------------------
    // Port itself never stores: the access is forwarded
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mem_o <= '0;
        end else if (take && to_data) begin
            mem_o.rd    <= !req_i.write;
            mem_o.wr    <= req_i.write;
            mem_o.addr  <= sel_mem_addr;
            mem_o.wdata <= req_i.wdata;
        end else begin
            mem_o.rd <= 1'b0;
            mem_o.wr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Flash strobes
    // ------------------------------------------------------------
    // Writes still pay the extra cycle but raise no strobe at all
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_rd_o   <= 1'b0;
            flash_addr_o <= 15'h0000;
        end else if (take && to_flash) begin
            flash_rd_o   <= !req_i.write;
            flash_addr_o <= sel_ptr[FLASH_AW-1:0];
        end else if (state == ST_FLASH2) begin
            flash_rd_o   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data and completion
    // ------------------------------------------------------------
    logic [DATA_W-1:0] data_byte;
    logic              finish;

    // Missing locations read as zero so stale bus values never leak
    assign data_byte = (zero_read || !mem_hit_i) ? ZERO_BYTE : mem_rdata_i;
    assign finish    = (state == ST_DATA) || (state == ST_FLASH2);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
            done_o  <= 1'b0;
        end else begin
            done_o <= finish;
            if (state == ST_DATA && !write_acc) begin
                rdata_o <= data_byte;
            end else if (state == ST_FLASH2 && !write_acc) begin
                rdata_o <= flash_rdata_i[DATA_W-1:0];
            end
        end
    end

endmodule

// ---- sim/iad_mem_model.sv ----
/*
 * Behavioural data memory and program flash facing the decoder.
 * Assumes the decoder strobes memory for one cycle and flash for two.
 */
`timescale 1ns/1ns

module iad_mem_model
    import iad_pkg::*;
(
    // Clock
    input  wire logic                         clk_i,
    // Data memory side
    input  wire iad_pkg::iad_mem_s            mem_i,
    output logic      [iad_pkg::DATA_W-1:0]   mem_rdata_o,
    output logic                              mem_hit_o,
    // Flash side
    input  wire logic                         flash_rd_i,
    input  wire logic [iad_pkg::FLASH_AW-1:0] flash_addr_i,
    output logic      [iad_pkg::FLASH_DW-1:0] flash_rdata_o
);
    logic [7:0] ram [4096];
    logic       fl_prev = 1'b0;
    logic [7:0] spin    = 8'h5C;  // Known start so the junk pattern is never unknown

    // -----------------------------------------------------------
    // Storage, same seed pattern as the bench shadow
    // -----------------------------------------------------------
    initial begin
        for (int a = 0; a < 4096; a++) begin
            ram[a] = 8'(a) ^ {4'(a >> 8), 4'(a >> 8)};
        end
    end

    // Writes land at the absolute address
    always @(posedge clk_i) begin
        if (mem_i.wr) begin
            ram[mem_i.addr] <= mem_i.wdata;
        end
        fl_prev <= flash_rd_i;
        spin    <= spin + 8'h3B;
    end

    // Bank 31 counts as unimplemented
    assign mem_hit_o   = mem_i.addr[11:7] != 5'h1F;
    // Outside a strobe the bus shows junk, not the last value
    assign mem_rdata_o = mem_i.rd ? ram[mem_i.addr] : ~ram[mem_i.addr];
    // Word only valid in the second strobe cycle
    assign flash_rdata_o = (flash_rd_i && fl_prev) ?
        {flash_addr_i[13:8], flash_addr_i[7:0] ^ 8'hA5} : {6'h2A, spin};
endmodule

// ---- sim/iad_decoder_chk.sv ----
/*
 * Port-level assertions for the indirect address decoder.
 * Assumes pointers are not reloaded in the cycle before a request.
 */
`timescale 1ns/1ns

module iad_decoder_chk
    import iad_pkg::*;
(
    input wire logic                         clk_i,
    input wire logic                         reset_i,
    input wire iad_pkg::iad_req_s            req_i,
    input wire logic                         busy_o,
    input wire logic                         done_o,
    input wire logic [iad_pkg::DATA_W-1:0]   rdata_o,
    input wire logic [iad_pkg::PTR_W-1:0]    ptr0_o,
    input wire logic [iad_pkg::PTR_W-1:0]    ptr1_o,
    input wire iad_pkg::iad_mem_s            mem_o,
    input wire logic                         mem_hit_i,
    input wire logic                         flash_rd_o,
    input wire logic [iad_pkg::FLASH_AW-1:0] flash_addr_o,
    input wire logic [iad_pkg::FLASH_DW-1:0] flash_rdata_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // -----------------------------------------------------------
    // Decode of the request being taken
    // -----------------------------------------------------------
    logic [15:0] last_sel;
    logic [7:0]  fl_byte;
    wire  [15:0] sel  = req_i.pair ? ptr1_o : ptr0_o;
    wire         take = req_i.valid && !busy_o;
    wire         fl   = take && sel[15];
    wire         trad = take && sel <= TRAD_LAST;
    wire         port = trad && sel[6:0] <= 7'h01;
    wire         strb = mem_o.rd || mem_o.wr;
    // Holes between the regions: nothing may reach memory
    wire         gap  = take && !sel[15] && sel > TRAD_LAST && (sel < LIN_FIRST || sel > LIN_LAST);

    // Held copies so consequents compare against the taken values
    always_ff @(posedge clk_i) begin
        last_sel <= sel;
        fl_byte  <= flash_rdata_i[7:0];
    end

    sequence s_wait1;
        busy_o && !done_o;
    endsequence
    sequence s_fin;
        done_o && !busy_o;
    endsequence

    AST_DONE_PULSE: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    AST_DATA_LAT: assert property (take && !sel[15] |-> ##1 s_wait1 ##1 s_fin)
        else $error("data access latency wrong");
    AST_FLASH_LAT: assert property (fl |-> ##1 s_wait1 [*2] ##1 s_fin)
        else $error("flash access latency wrong");
    AST_FLASH_ADDR: assert property (fl && !req_i.write |=> flash_rd_o && flash_addr_o == last_sel[14:0])
        else $error("flash address wrong");
    AST_FLASH_RO: assert property (fl |=> !mem_o.wr [*3]) else $error("flash write reached memory");
    AST_TRAD_ADDR: assert property (trad && !port |=> strb && mem_o.addr == last_sel[11:0])
        else $error("traditional address wrong");
    AST_PORT_ZERO: assert property (port && !req_i.write |-> ##1 !strb ##1 rdata_o == 8'h00)
        else $error("port read not zero");
    AST_LIN_GPR: assert property (take && sel >= LIN_FIRST && sel <= LIN_LAST |=>
        strb && mem_o.addr[6:0] >= 7'h20 && mem_o.addr[6:0] <= 7'h6F) else $error("linear hit outside ram");
    AST_FLASH_BYTE: assert property (flash_rd_o && $past(flash_rd_o) |=> rdata_o == fl_byte)
        else $error("flash byte wrong");
    AST_UNIMP_ZERO: assert property (mem_o.rd && !mem_hit_i |=> rdata_o == 8'h00)
        else $error("unimplemented read not zero");
    AST_PORT_DROP: assert property (port && req_i.write |=> !strb)
        else $error("port write reached memory");
    AST_GAP_DROP: assert property (gap |=> !strb)
        else $error("gap access reached memory");
    AST_FLASH_NOWR: assert property (fl && req_i.write |=> !flash_rd_o [*2])
        else $error("flash write raised a strobe");
endmodule

bind iad_decoder iad_decoder_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .busy_o(busy_o),
    .done_o(done_o), .rdata_o(rdata_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .mem_o(mem_o), .mem_hit_i(mem_hit_i),
    .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_rdata_i(flash_rdata_i));

// ---- sim/iad_decoder_bench.sv ----
/*
 * Self-checking bench for the indirect address decoder with a memory
 * and flash model behind it. Assumes the model's seed pattern below.
 */
`timescale 1ns/1ns

module iad_decoder_bench;
    import iad_pkg::*;

    logic        clk_i = 0;
    logic        reset_i = 1;
    iad_ptr_wr_s ptr_wr = '0;
    iad_req_s    req = '0;
    iad_mem_s    mem;
    logic        busy_o, done_o, mem_hit, flash_rd;
    logic [7:0]  rdata, mem_rdata;
    logic [15:0] ptr0, ptr1;
    logic [14:0] flash_addr;
    logic [13:0] flash_rdata;
    logic [7:0]  ram_s [4096];
    int          fail_count = 0;
    int          check_count = 0;
    logic [15:0] corner [12] = '{16'h0000, 16'h0081, 16'h0020, 16'h0FFF, 16'h2000, 16'h204F,
                                 16'h2050, 16'h29AF, 16'h29B0, 16'h1000, 16'h8000, 16'hFFFF};

    always #4 clk_i = ~clk_i;

    iad_decoder dut (.clk_i(clk_i), .reset_i(reset_i), .ptr_wr_i(ptr_wr), .req_i(req), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata), .ptr0_o(ptr0), .ptr1_o(ptr1), .mem_o(mem), .mem_rdata_i(mem_rdata),
        .mem_hit_i(mem_hit), .flash_rd_o(flash_rd), .flash_addr_o(flash_addr), .flash_rdata_i(flash_rdata));
    iad_mem_model u_mem (.clk_i(clk_i), .mem_i(mem), .mem_rdata_o(mem_rdata), .mem_hit_o(mem_hit),
        .flash_rd_i(flash_rd), .flash_addr_i(flash_addr), .flash_rdata_o(flash_rdata));

    // -----------------------------------------------------------
    // Expectations
    // -----------------------------------------------------------
    function automatic logic [11:0] exp_addr(input logic [15:0] p);
        int o;
        o = int'(p) - 32'h2000;
        if (p <= 16'h0FFF) return p[11:0];
        return {5'(o / 80), 7'(32'h20 + o % 80)};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [15:0] p);
        logic [11:0] a;
        a = exp_addr(p);
        if (p[15]) return p[7:0] ^ 8'hA5;
        if (p > 16'h29AF || (p > 16'h0FFF && p < 16'h2000)) return 8'h00;
        if (p <= 16'h0FFF && (a[6:0] <= 7'h01 || a[11:7] == 5'h1F)) return 8'h00;
        return ram_s[a];
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic set_ptr(input logic pr, input logic [15:0] p);
        @(posedge clk_i) ptr_wr <= {1'b1, pr, 1'b1, p[15:8]};
        @(posedge clk_i) ptr_wr <= {1'b1, pr, 1'b0, p[7:0]};
        @(posedge clk_i) ptr_wr <= '0;
        @(posedge clk_i);
        @(negedge clk_i) chk("pointer", pr ? ptr1 : ptr0, p);
    endtask

    task automatic acc(input logic pr, input logic wr, input logic [7:0] wd, output int n);
        @(posedge clk_i) req <= {1'b1, pr, wr, wd};
        @(posedge clk_i) req <= '0;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 8);
    endtask

    // Write then read back through one pair while the other holds a decoy
    task automatic run(input logic pr, input logic [15:0] p, input logic [7:0] wd);
        int n;
        logic [11:0] a;
        a = exp_addr(p);
        set_ptr(pr, p);
        set_ptr(!pr, p ^ 16'h0155);
        acc(pr, 1'b1, wd, n);
        chk("write latency", 16'(n), p[15] ? 16'h3 : 16'h2);
        if (!p[15] && p <= 16'h29AF && (p >= 16'h2000 || (p <= 16'h0FFF && a[6:0] > 7'h01))) ram_s[a] = wd;
        acc(pr, 1'b0, 8'h00, n);
        chk("read latency", 16'(n), p[15] ? 16'h3 : 16'h2);
        chk("read data", {8'h00, rdata}, {8'h00, exp_rd(p)});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // -----------------------------------------------------------
    // Main sequence: corners on both pairs, then random traffic
    // -----------------------------------------------------------
    initial begin
        logic [15:0] p;
        int          n;
        for (int a = 0; a < 4096; a++) ram_s[a] = 8'(a) ^ {4'(a >> 8), 4'(a >> 8)};
        void'($urandom(14));
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (corner[i]) begin
            run(1'b0, corner[i], 8'(i * 37 + 5));
            run(1'b1, corner[i], 8'(i * 19 + 2));
        end
        $display("corner test done");
        // Mid-run reset: pointers and results clear, first access right after release
        @(posedge clk_i) reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("reset pointer0", ptr0, 16'h0000);
        chk("reset pointer1", ptr1, 16'h0000);
        chk("reset rdata", {8'h00, rdata}, 16'h0000);
        chk("reset busy done", {14'h0000, busy_o, done_o}, 16'h0000);
        @(posedge clk_i) reset_i <= 1'b0;
        acc(1'b0, 1'b0, 8'h00, n);
        chk("post reset latency", 16'(n), 16'h2);
        chk("post reset data", {8'h00, rdata}, 16'h0000);
        $display("reset test done");
        for (int k = 0; k < 300; k++) begin
            case ($urandom % 4)
                0: p = {4'h0, 12'($urandom)};
                1: p = 16'h2000 + 16'($urandom % 2480);
                2: p = {1'b1, 15'($urandom)};
                default: p = 16'h1000 + 16'($urandom % 4096);
            endcase
            run(1'($urandom), p, 8'($urandom));
        end
        $display("random test done");
        end_sim();
    end

    // Watchdog well past the expected run of about 4700 cycles
    initial begin
        #(8 * 80000);
        fail_count++;
        end_sim();
    end
endmodule
